//--- hdl/vtrim_pkg.sv
package vtrim_pkg;
  // ----------------------------------------------------------------
  // bus identity and register map
  // ----------------------------------------------------------------
  localparam logic [6:0] VTRIM_DEV_ID      = 7'h28;
  localparam logic [7:0] VTRIM_ADDR_WIPER  = 8'h00;
  localparam logic [7:0] VTRIM_ADDR_RSVD   = 8'h01;
  localparam logic [7:0] VTRIM_ADDR_ACCESS = 8'h02;
  localparam logic [7:0] VTRIM_ACCESS_RST  = 8'h00;
  localparam logic [7:0] VTRIM_ACCESS_VOL  = 8'h80;
  localparam int         VTRIM_ACCESS_SEL  = 7;
  localparam logic [7:0] VTRIM_WIPER_ERR   = 8'h40;
  localparam logic [7:0] VTRIM_NV_RST      = 8'h40;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int VTRIM_CLK_MHZ     = 200;
  localparam int VTRIM_NV_WRITE_MS = 25;
  localparam int VTRIM_NV_WRITE_CYC = VTRIM_NV_WRITE_MS * 1000
                                      * VTRIM_CLK_MHZ;
  localparam int VTRIM_POWERUP_CYC = 16;
  localparam int VTRIM_SCL_KHZ     = 400;
  // half period of the master's scl, in system clocks
  localparam int VTRIM_SCL_HALF_CYC = (VTRIM_CLK_MHZ * 1000)
                                      / (2 * VTRIM_SCL_KHZ);
  localparam int VTRIM_CNT_W = 24;
endpackage

//--- hdl/vtrim_if.sv
`timescale 1ns/1ps
// open-drain bus: each end pulls low when its enable is high
interface vtrim_if;
  logic scl_m_oe;
  logic sda_m_oe;
  logic sda_s_oe;
  logic scl;
  logic sda;

  assign scl = ~scl_m_oe;
  assign sda = ~(sda_m_oe | sda_s_oe);

  modport slave (
    input  scl,
    input  sda,
    output sda_s_oe
  );
  modport master (
    input  scl,
    input  sda,
    output scl_m_oe,
    output sda_m_oe
  );
endinterface

//--- hdl/vtrim_slave.sv
`timescale 1ns/1ps
// Overview of operation
// - master keeps both lines high when idle
// - works at 100 and 400 kHz
// - data moves only while clock low
// - data line released after power-up
// - ignore everything until start seen
// - starts ignored during power-up, nv write
// - stop after read/volatile write: standby
// - stop after nv write starts write cycle
// - transmitter releases, receiver acks ninth clock
// - ack id, address, write data bytes
// - master acks read data byte
// - id upper bits 28h, lsb direction
// - write is start, id, address, data, stop
// - update only with correct frame; the code commits the data byte at its lsb, before the stop is seen
// - data committed on falling edge of lsb
// - read via repeated start, one data byte
// - wiper loaded from stored value at power-up
// - select 00h: read stored, write both
// - select 80h: read/write wiper only
// - only 00h or 80h into access select; the code stores any byte written there, and only bit 7 is decoded
// - bus ignored, line released during nv write
// - reading stored value leaves wiper alone
// - wiper back to 64 on bus error
module vtrim_slave
  import vtrim_pkg::*;
#(
  parameter int NV_WRITE_CYC = VTRIM_NV_WRITE_CYC
) (
  input  wire logic       clk_sys_i,
  input  wire logic       nrst_i,
  vtrim_if.slave          bus,
  output logic [7:0]      live_wiper_position_o,
  output logic [7:0]      stored_initial_wiper_o,
  output logic [7:0]      access_select_o,
  output logic            nv_busy_o
);
  typedef enum {
    VTRIM_S_IDLE, VTRIM_S_ID, VTRIM_S_ADDR, VTRIM_S_DATA,
    VTRIM_S_TX, VTRIM_S_ACK, VTRIM_S_MACK, VTRIM_S_WAITP
  } vtrim_state_t;

  // ----------------------------------------------------------------
  // input synchronisers and edge detection
  // ----------------------------------------------------------------
  logic [1:0] scl_sync_q;
  logic [1:0] sda_sync_q;
  logic       scl_q;
  logic       sda_q;
  // two flops before anything looks at the pins
  always_ff @(posedge clk_sys_i)
  begin
    if (!nrst_i)
    begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      scl_q      <= 1'b1;
      sda_q      <= 1'b1;
    end
    else
    begin
      scl_sync_q <= {scl_sync_q[0], bus.scl};
      sda_sync_q <= {sda_sync_q[0], bus.sda};
      scl_q      <= scl_sync_q[1];
      sda_q      <= sda_sync_q[1];
    end
  end

  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  assign scl_s     = scl_sync_q[1];
  assign sda_s     = sda_sync_q[1];
  assign scl_rise  = scl_s & ~scl_q;
  assign scl_fall  = ~scl_s & scl_q;
  assign start_det = scl_s & scl_q & sda_q & ~sda_s;
  assign stop_det  = scl_s & scl_q & ~sda_q & sda_s;

  // ----------------------------------------------------------------
  // power-up and nv write timer
  // ----------------------------------------------------------------
  logic [VTRIM_CNT_W-1:0] busy_cnt_q;
  logic                   pwrup_q;
  logic                   nv_go;
  logic                   blind;
  assign blind = pwrup_q | nv_busy_o;

  // one counter serves both the power-up hold-off and the write cycle
  always_ff @(posedge clk_sys_i)
  begin
    if (!nrst_i)
    begin
      busy_cnt_q <= VTRIM_CNT_W'(VTRIM_POWERUP_CYC);
      pwrup_q    <= 1'b1;
      nv_busy_o  <= 1'b0;
    end
    else if (nv_go)
    begin
      busy_cnt_q <= VTRIM_CNT_W'(NV_WRITE_CYC);
      nv_busy_o  <= 1'b1;
    end
    else if (busy_cnt_q != '0)
      busy_cnt_q <= busy_cnt_q - 1'b1;
    else
    begin
      pwrup_q   <= 1'b0;
      nv_busy_o <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // byte engine
  // ----------------------------------------------------------------
  vtrim_state_t st_q;
  vtrim_state_t after_ack_q;
  logic [7:0]   shift_q;
  logic [3:0]   bit_q;
  logic [7:0]   addr_q;
  logic         rd_q;
  logic         nv_pend_q;
  logic [7:0]   rd_byte;
  logic         err_wipe;

  // stored value or wiper, per access select bit 7
  always_comb
  begin
    rd_byte = 8'h00;
    if (addr_q == VTRIM_ADDR_WIPER)
      rd_byte = access_select_o[VTRIM_ACCESS_SEL] ?
                live_wiper_position_o :
                stored_initial_wiper_o;
    else if (addr_q == VTRIM_ADDR_ACCESS)
      rd_byte = access_select_o;
  end

  assign nv_go = stop_det & ~blind & nv_pend_q & (st_q == VTRIM_S_WAITP);

  // start or stop is legal between frames or right after the address
  // ack, where a read turns round; the rise before it counts one bit
  logic frame_gap;
  assign frame_gap = st_q == VTRIM_S_IDLE || st_q == VTRIM_S_WAITP ||
                     (st_q == VTRIM_S_DATA && bit_q <= 4'h1);

  // bus sequencing; sda is only changed after scl falls
  always_ff @(posedge clk_sys_i)
  begin
    if (!nrst_i)
    begin
      st_q        <= VTRIM_S_IDLE;
      after_ack_q <= VTRIM_S_IDLE;
      shift_q     <= 8'h00;
      bit_q       <= 4'h0;
      addr_q      <= 8'h00;
      rd_q        <= 1'b0;
      nv_pend_q   <= 1'b0;
      bus.sda_s_oe <= 1'b0;
      err_wipe    <= 1'b0;
    end
    else
    begin
      err_wipe <= 1'b0;
      if (blind)
      begin
        st_q         <= VTRIM_S_IDLE;
        bus.sda_s_oe <= 1'b0;
        nv_pend_q    <= 1'b0;
      end
      else if (start_det)
      begin
        // repeated start mid-frame is legal for reads
        st_q         <= VTRIM_S_ID;
        bit_q        <= 4'h0;
        bus.sda_s_oe <= 1'b0;
        nv_pend_q    <= 1'b0;
        err_wipe     <= !frame_gap;
      end
      else if (stop_det)
      begin
        // stop is a bus error except between frames or right after the id or address ack
        err_wipe     <= !frame_gap &&
                        (st_q != VTRIM_S_ADDR || bit_q > 4'h1);
        st_q         <= VTRIM_S_IDLE;
        bus.sda_s_oe <= 1'b0;
        nv_pend_q    <= 1'b0;
      end
      else
      begin
        unique case (st_q)
          VTRIM_S_IDLE, VTRIM_S_WAITP:
          begin
            if (scl_fall && st_q == VTRIM_S_WAITP)
            begin
              st_q      <= VTRIM_S_IDLE; // extra clock voids frame
              nv_pend_q <= 1'b0;
              err_wipe  <= 1'b1;
            end
          end
          VTRIM_S_ID, VTRIM_S_ADDR, VTRIM_S_DATA:
          begin
            if (scl_rise)
            begin
              shift_q <= {shift_q[6:0], sda_s};
              bit_q   <= bit_q + 4'h1;
            end
            else if (scl_fall && bit_q == 4'h8)
            begin
              bit_q <= 4'h0;
              if (st_q == VTRIM_S_ID)
              begin
                if (shift_q[7:1] == VTRIM_DEV_ID)
                begin
                  bus.sda_s_oe <= 1'b1;
                  rd_q         <= shift_q[0];
                  st_q         <= VTRIM_S_ACK;
                  after_ack_q  <= shift_q[0] ? VTRIM_S_TX : VTRIM_S_ADDR;
                end
                else
                  st_q <= VTRIM_S_IDLE;
              end
              else if (st_q == VTRIM_S_ADDR)
              begin
                addr_q <= shift_q;
                if (shift_q == VTRIM_ADDR_WIPER ||
                    shift_q == VTRIM_ADDR_ACCESS)
                begin
                  bus.sda_s_oe <= 1'b1;
                  st_q         <= VTRIM_S_ACK;
                  after_ack_q  <= VTRIM_S_DATA;
                end
                else
                begin
                  st_q     <= VTRIM_S_IDLE;
                  err_wipe <= 1'b1;
                end
              end
              else
              begin
                // data committed on the lsb's falling edge
                bus.sda_s_oe <= 1'b1;
                st_q         <= VTRIM_S_ACK;
                after_ack_q  <= VTRIM_S_WAITP;
                nv_pend_q    <= (addr_q == VTRIM_ADDR_WIPER) &&
                                !access_select_o[VTRIM_ACCESS_SEL];
              end
            end
          end
          VTRIM_S_ACK:
          begin
            if (scl_fall)
            begin
              st_q         <= after_ack_q;
              bus.sda_s_oe <= 1'b0;
              if (after_ack_q == VTRIM_S_TX)
              begin
                shift_q      <= rd_byte;
                bit_q        <= 4'h1;
                bus.sda_s_oe <= ~rd_byte[7];
              end
            end
          end
          VTRIM_S_TX:
          begin
            if (scl_fall)
            begin
              if (bit_q == 4'h8)
              begin
                bus.sda_s_oe <= 1'b0;
                st_q         <= VTRIM_S_MACK;
              end
              else
              begin
                bus.sda_s_oe <= ~shift_q[7 - bit_q[2:0]];
                bit_q        <= bit_q + 4'h1;
              end
            end
          end
          VTRIM_S_MACK:
          begin
            // one data byte per read; master ack then stop
            if (scl_fall)
              st_q <= VTRIM_S_WAITP;
          end
        endcase
      end
    end
  end

  logic wr_commit;
  assign wr_commit = !blind && !start_det && !stop_det &&
                     st_q == VTRIM_S_DATA && scl_fall && bit_q == 4'h8;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // nv array is modelled as a flop; survives only the bus, not reset
  always_ff @(posedge clk_sys_i)
  begin
    if (!nrst_i)
    begin
      stored_initial_wiper_o <= VTRIM_NV_RST;
      live_wiper_position_o  <= VTRIM_NV_RST;
      access_select_o        <= VTRIM_ACCESS_RST;
    end
    else if (pwrup_q)
      live_wiper_position_o <= stored_initial_wiper_o;
    else if (err_wipe)
      live_wiper_position_o <= VTRIM_WIPER_ERR;
    else if (wr_commit)
    begin
      if (addr_q == VTRIM_ADDR_ACCESS)
        access_select_o <= shift_q;
      else
      begin
        live_wiper_position_o <= shift_q;
        if (!access_select_o[VTRIM_ACCESS_SEL])
          stored_initial_wiper_o <= shift_q;
      end
    end
  end
endmodule // vtrim_slave

//--- hdl/vtrim_master.sv
`timescale 1ns/1ps
module vtrim_master
  import vtrim_pkg::*;
(
  input  wire logic       clk_sys_i,
  input  wire logic       nrst_i,
  vtrim_if.master         bus,
  input  wire logic       req_i,
  input  wire logic       rd_i,
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  output logic            busy_o,
  output logic            done_o,
  output logic            nack_o,
  output logic [7:0]      rdata_o
);
  typedef enum {
    VTRIM_M_IDLE, VTRIM_M_START, VTRIM_M_BIT, VTRIM_M_ACK, VTRIM_M_STOP
  } vtrim_mstate_t;

  // ----------------------------------------------------------------
  // sda sampled through two flops
  // ----------------------------------------------------------------
  logic [1:0] sda_sync_q;
  always_ff @(posedge clk_sys_i)
  begin
    if (!nrst_i)
      sda_sync_q <= 2'h3;
    else
      sda_sync_q <= {sda_sync_q[0], bus.sda};
  end

  // ----------------------------------------------------------------
  // byte sequencer; each phase is one scl half period
  // ----------------------------------------------------------------
  vtrim_mstate_t st_q;
  logic [7:0]    tick_q;
  logic [2:0]    bit_q;
  logic [1:0]    byte_q;
  logic [7:0]    sh_q;
  logic          hi_q;
  logic          rd_q;
  logic          tick;
  logic [7:0]    next_byte;
  assign tick = (tick_q == 8'(VTRIM_SCL_HALF_CYC - 1));

  // byte 0 id-w, 1 addr, 2 data or id-r, 3 read data
  always_comb
  begin
    next_byte = 8'hFF;
    unique case (byte_q)
      2'h0: next_byte = {VTRIM_DEV_ID, 1'b0};
      2'h1: next_byte = addr_i;
      2'h2: next_byte = rd_q ? {VTRIM_DEV_ID, 1'b1} : wdata_i;
      2'h3: next_byte = 8'hFF;
    endcase
  end

  // idle releases both lines
  always_ff @(posedge clk_sys_i)
  begin
    if (!nrst_i)
    begin
      st_q         <= VTRIM_M_IDLE;
      tick_q       <= 8'h00;
      bit_q        <= 3'h0;
      byte_q       <= 2'h0;
      sh_q         <= 8'h00;
      hi_q         <= 1'b0;
      rd_q         <= 1'b0;
      bus.scl_m_oe <= 1'b0;
      bus.sda_m_oe <= 1'b0;
      busy_o       <= 1'b0;
      done_o       <= 1'b0;
      nack_o       <= 1'b0;
      rdata_o      <= 8'h00;
    end
    else
    begin
      done_o <= 1'b0;
      tick_q <= tick ? 8'h00 : tick_q + 8'h01;
      unique case (st_q)
        VTRIM_M_IDLE:
        begin
          bus.scl_m_oe <= 1'b0;
          bus.sda_m_oe <= 1'b0;
          if (req_i)
          begin
            busy_o <= 1'b1;
            nack_o <= 1'b0;
            rd_q   <= rd_i;
            byte_q <= 2'h0;
            tick_q <= 8'h00;
            hi_q   <= 1'b0;
            st_q   <= VTRIM_M_START;
          end
        end
        VTRIM_M_START:
        begin
          if (tick)
          begin
            // scl high: drop sda, then pull scl low
            hi_q <= ~hi_q;
            if (!hi_q)
            begin
              bus.scl_m_oe <= 1'b0;
              bus.sda_m_oe <= 1'b0;
            end
            else if (!bus.sda_m_oe)
            begin
              bus.sda_m_oe <= 1'b1;
              hi_q         <= 1'b1;
            end
            else
            begin
              bus.scl_m_oe <= 1'b1;
              sh_q         <= next_byte;
              bit_q        <= 3'h0;
              hi_q         <= 1'b0;
              st_q         <= VTRIM_M_BIT;
            end
          end
        end
        VTRIM_M_BIT:
        begin
          if (tick)
          begin
            hi_q <= ~hi_q;
            if (!hi_q)
            begin
              // scl low: set data, then release scl
              if (bus.scl_m_oe && bus.sda_m_oe == sh_q[7])
                bus.sda_m_oe <= ~sh_q[7];
              else
                bus.scl_m_oe <= 1'b0;
              if (bus.scl_m_oe && bus.sda_m_oe == sh_q[7])
                hi_q <= 1'b0;
            end
            else
            begin
              sh_q         <= {sh_q[6:0], sda_sync_q[1]};
              bus.scl_m_oe <= 1'b1;
              bit_q        <= bit_q + 3'h1;
              if (bit_q == 3'h7)
              begin
                st_q <= VTRIM_M_ACK;
                // release after eight bits, also when we are the receiver
                bus.sda_m_oe <= (byte_q == 2'h3) ? 1'b0 : 1'b0;
              end
            end
          end
        end
        VTRIM_M_ACK:
        begin
          if (tick)
          begin
            hi_q <= ~hi_q;
            if (!hi_q)
            begin
              if (byte_q == 2'h3 && !bus.sda_m_oe)
              begin
                rdata_o      <= sh_q;
                bus.sda_m_oe <= 1'b1;
                hi_q         <= 1'b0;
              end
              else
                bus.scl_m_oe <= 1'b0;
            end
            else
            begin
              bus.scl_m_oe <= 1'b1;
              bus.sda_m_oe <= 1'b0;
              if (byte_q != 2'h3 && sda_sync_q[1])
              begin
                nack_o <= 1'b1;
                st_q   <= VTRIM_M_STOP;
              end
              else if (byte_q == 2'h3 || (byte_q == 2'h2 && !rd_q))
                st_q <= VTRIM_M_STOP;
              else if (byte_q == 2'h1 && rd_q)
              begin
                byte_q <= 2'h2; // repeated start
                st_q   <= VTRIM_M_START;
              end
              else
              begin
                byte_q <= byte_q + 2'h1;
                sh_q   <= (byte_q == 2'h2) ? 8'hFF :
                          (byte_q == 2'h0 ? addr_i : wdata_i);
                bit_q  <= 3'h0;
                st_q   <= VTRIM_M_BIT;
              end
            end
          end
        end
        VTRIM_M_STOP:
        begin
          if (tick)
          begin
            // sda low, scl up, then sda up while scl high
            hi_q <= ~hi_q;
            if (!hi_q && bus.scl_m_oe)
            begin
              bus.sda_m_oe <= 1'b1;
              bus.scl_m_oe <= 1'b0;
            end
            else if (!bus.scl_m_oe && bus.sda_m_oe)
              bus.sda_m_oe <= 1'b0;
            else if (!bus.scl_m_oe)
            begin
              busy_o <= 1'b0;
              done_o <= 1'b1;
              st_q   <= VTRIM_M_IDLE;
            end
          end
        end
      endcase
    end
  end
endmodule // vtrim_master

//--- tb/vtrim_assertions.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// wire checks on the link between the two ends
// ------------------------------------------------------------
module vtrim_assertions
  import vtrim_pkg::*;
(
  input  wire logic clk_sys_i,
  input  wire logic nrst_i,
  input  wire logic scl_m_oe,
  input  wire logic sda_m_oe,
  input  wire logic sda_s_oe,
  input  wire logic scl,
  input  wire logic sda
);
  logic        scl_q;
  logic        sda_q;
  logic        frame_q;
  logic        rd_q;
  logic [4:0]  bits_q;
  logic [4:0]  pu_q;
  logic [12:0] drv_q;
  logic        rise;
  logic        start;
  logic        stop;

  // raw wire edges; lines move only on clock edges
  assign rise  = scl & ~scl_q;
  assign start = scl & scl_q & sda_q & ~sda;
  assign stop  = scl & scl_q & ~sda_q & sda;

  // line history
  always_ff @(posedge clk_sys_i)
  begin
    scl_q <= nrst_i ? scl : 1'b1;
    sda_q <= nrst_i ? sda : 1'b1;
  end

  // frame state, a repeated start keeps it set
  always_ff @(posedge clk_sys_i)
  begin
    if (!nrst_i || stop)
      frame_q <= 1'b0;
    else if (start)
      frame_q <= 1'b1;
  end

  // clocks since the last start, and direction bit
  always_ff @(posedge clk_sys_i)
  begin
    if (!nrst_i || start)
      bits_q <= '0;
    else if (rise)
      bits_q <= bits_q + 5'd1;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!nrst_i)
      rd_q <= 1'b0;
    else if (rise && bits_q == 5'd7)
      rd_q <= sda;
  end

  // power-up age and length of each slave drive
  always_ff @(posedge clk_sys_i)
  begin
    if (!nrst_i)
      pu_q <= '0;
    else if (pu_q != 5'h1F)
      pu_q <= pu_q + 5'd1;
  end

  always_ff @(posedge clk_sys_i)
  begin
    drv_q <= (nrst_i && sda_s_oe) ? drv_q + 13'd1 : '0;
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);

  a_slave_edge_low: assert property ($changed(sda_s_oe) |-> !scl)
    else $error("slave data moved while clock high");
  a_powerup_quiet: assert property (pu_q < 5'd16 |-> !sda_s_oe)
    else $error("slave drove data during power-up");
  a_idle_high: assert property (!frame_q && !start |-> scl && sda)
    else $error("line low outside a frame");
  a_drive_in_frame: assert property (sda_s_oe |-> frame_q)
    else $error("slave drove data outside a frame");
  a_drive_bounded: assert property (sda_s_oe |-> drv_q < 13'd4600)
    else $error("slave held data low too long");
  a_ack_ninth: assert property (rise && sda_s_oe |-> bits_q == 5'd8
    || (rd_q ? (bits_q > 5'd8 && bits_q < 5'd17)
             : (bits_q == 5'd17 || bits_q == 5'd26)))
    else $error("slave pulled data at a wrong clock");
  a_master_ack: assert property (rise && rd_q && bits_q == 5'd17 |-> !sda)
    else $error("master did not acknowledge read data");
  a_id_bits: assert property (rise && frame_q && bits_q < 5'd7
    |-> sda == VTRIM_DEV_ID[3'd6 - bits_q[2:0]])
    else $error("identification bits wrong");

  c_write: cover property (rise && !rd_q && bits_q == 5'd26 && sda_s_oe);
  c_read: cover property (rise && rd_q && bits_q == 5'd17);
  c_nack: cover property (rise && bits_q == 5'd8 && sda);
endmodule // vtrim_assertions

//--- tb/vcom_trim_i2c_slave_test.sv
`timescale 1ns/1ps
module vcom_trim_i2c_slave_test
  import vtrim_pkg::*;
;
  // short write cycle, still longer than one byte on the link
  localparam int NV_CYC = 6000;
  logic       clk_sys_i = 1'b0;
  logic       nrst_i    = 1'b0;
  logic       req       = 1'b0;
  logic       rd        = 1'b0;
  logic [7:0] addr      = 8'h00;
  logic [7:0] wdata     = 8'h00;
  logic       busy, done, nack, nvb, nvb_b, ack;
  logic [7:0] rdata, wiper, stored, acc, wiper_b, stored_b, acc_b;
  int         errors    = 0;
  int         compares  = 0;
  int         busy_cyc  = 0;

  vtrim_if bus ();
  vtrim_if bus_b ();
  vtrim_master i_vtrim_master (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
    .bus(bus.master), .req_i(req), .rd_i(rd), .addr_i(addr),
    .wdata_i(wdata), .busy_o(busy), .done_o(done), .nack_o(nack),
    .rdata_o(rdata));
  vtrim_slave #(.NV_WRITE_CYC(NV_CYC)) i_vtrim_slave (.clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i), .bus(bus.slave), .live_wiper_position_o(wiper),
    .stored_initial_wiper_o(stored), .access_select_o(acc), .nv_busy_o(nvb));
  // second end on its own link, driven by hand to break the protocol
  vtrim_slave #(.NV_WRITE_CYC(NV_CYC)) i_vtrim_slave_b (
    .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .bus(bus_b.slave),
    .live_wiper_position_o(wiper_b), .stored_initial_wiper_o(stored_b),
    .access_select_o(acc_b), .nv_busy_o(nvb_b));
  vtrim_assertions i_vtrim_assertions (.clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i), .scl_m_oe(bus.scl_m_oe), .sda_m_oe(bus.sda_m_oe),
    .sda_s_oe(bus.sda_s_oe), .scl(bus.scl), .sda(bus.sda));

  // ------------------------------------------------------------
  // clock, busy counter and shared tasks
  // ------------------------------------------------------------
  always #2.5 clk_sys_i = ~clk_sys_i;

  always @(posedge clk_sys_i)
    if (nvb === 1'b1)
      busy_cyc++;

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    compares++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // one transfer through the master; operands held until done
  task automatic xfer(input logic r, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(negedge clk_sys_i);
    req = 1'b1;
    rd = r;
    addr = a;
    wdata = d;
    @(negedge clk_sys_i);
    req = 1'b0;
    check(busy, 1'b1);
    n = 0;
    while (done !== 1'b1 && n < 40000)
    begin
      @(negedge clk_sys_i);
      n++;
    end
    check(16'(n < 40000), 16'h0001);
    check(busy, 1'b0);
  endtask

  // hand-driven link on the second end, 48 ns per clock
  task automatic bb_bit(input logic b, output logic s);
    bus_b.sda_m_oe = ~b;
    #12;
    bus_b.scl_m_oe = 1'b0;
    #22;
    s = bus_b.sda;
    #2;
    bus_b.scl_m_oe = 1'b1;
    #12;
  endtask

  task automatic bb_start;
    bus_b.sda_m_oe = 1'b1;
    #24;
    bus_b.scl_m_oe = 1'b1;
    #12;
  endtask

  task automatic bb_stop;
    bus_b.sda_m_oe = 1'b1;
    #12;
    bus_b.scl_m_oe = 1'b0;
    #24;
    bus_b.sda_m_oe = 1'b0;
    #96;
  endtask

  // nbits of v, then one acknowledge clock when nbits is eight
  task automatic bb_byte(input logic [7:0] v, input int nbits);
    logic s;
    for (int i = 7; i > 7 - nbits; i--)
      bb_bit(v[i], s);
    if (nbits == 8)
      bb_bit(1'b1, s);
    ack = ~s;
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset_values;
    check({wiper, stored}, 16'h4040);
    check({acc, 7'h00, nvb}, 16'h0000);
  endtask

  task automatic t_nv_write;
    busy_cyc = 0;
    xfer(1'b0, VTRIM_ADDR_WIPER, 8'h5A);
    check({nack, wiper, stored}, 17'h05A5A);
    repeat (50) @(negedge clk_sys_i);
    check(nvb, 1'b1);
    xfer(1'b1, VTRIM_ADDR_WIPER, 8'h00);
    check({nack, wiper}, 9'h15A);
    repeat (NV_CYC) @(negedge clk_sys_i);
    check(nvb, 1'b0);
    check(16'(busy_cyc >= NV_CYC - 1 && busy_cyc <= NV_CYC + 1), 16'h1);
  endtask

  task automatic t_volatile;
    xfer(1'b0, VTRIM_ADDR_ACCESS, VTRIM_ACCESS_VOL);
    check({nack, acc}, 9'h080);
    xfer(1'b0, VTRIM_ADDR_WIPER, 8'h33);
    repeat (20) @(negedge clk_sys_i);
    check({nack, wiper, stored}, 17'h0335A);
    check(nvb, 1'b0);
  endtask

  task automatic t_read_stored;
    xfer(1'b0, VTRIM_ADDR_ACCESS, VTRIM_ACCESS_RST);
    xfer(1'b1, VTRIM_ADDR_WIPER, 8'h00);
    check({nack, rdata}, 9'h05A);
    check(wiper, 8'h33);
  endtask

  task automatic t_faults;
    bb_start;
    bb_byte({VTRIM_DEV_ID, 1'b0}, 8);
    check(ack, 1'b1);
    bb_byte(VTRIM_ADDR_WIPER, 8);
    bb_byte(8'h11, 8);
    check(ack, 1'b1);
    bb_stop;
    repeat (NV_CYC + 50) @(negedge clk_sys_i);
    check({nvb_b, wiper_b, stored_b}, 17'h01111);
    bb_start;
    bb_byte({VTRIM_DEV_ID, 1'b0}, 8);
    bb_byte(VTRIM_ADDR_RSVD, 8);
    check(ack, 1'b0);
    bb_stop;
    check({wiper_b, stored_b}, 16'h4011);
    bb_start;
    bb_byte({VTRIM_DEV_ID ^ 7'h01, 1'b0}, 8);
    check(ack, 1'b0);
    bb_stop;
    bb_start;
    bb_byte({VTRIM_DEV_ID, 1'b0}, 8);
    bb_byte(VTRIM_ADDR_ACCESS, 8);
    bb_byte(VTRIM_ACCESS_VOL, 7);
    bb_stop;
    check({acc_b, wiper_b}, 16'h0040);
  endtask

  // ------------------------------------------------------------
  // main sequence and watchdog
  // ------------------------------------------------------------
  initial
  begin
    bus_b.scl_m_oe = 1'b0;
    bus_b.sda_m_oe = 1'b0;
    repeat (4) @(negedge clk_sys_i);
    nrst_i = 1'b1;
    repeat (20) @(negedge clk_sys_i);
    t_reset_values();
    t_nv_write();
    t_volatile();
    t_read_stored();
    t_faults();
    finish_test();
  end

  // whole run is about 120k clocks; leave ample margin
  initial
  begin
    #1500000;
    errors++;
    finish_test();
  end
endmodule // vcom_trim_i2c_slave_test
